/* File: verilog/nvm_cfg.svh */
// constants for the nonvolatile data memory access controller
// assumes an APB slave with 32-bit data and byte addresses
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH

// register byte offsets
`define NVM_OFS_CONTROL   8'h00
`define NVM_OFS_SEQUENCE  8'h04
`define NVM_OFS_DATA      8'h08
`define NVM_OFS_LOCATION  8'h0C
`define NVM_OFS_FLAGS     8'h10
`define NVM_OFS_MASK      8'h14

// nvm_control field positions
`define NVM_BIT_PSS       7
`define NVM_BIT_CONFIG_SPACE_SELECT      6
`define NVM_BIT_FAULT     3
`define NVM_BIT_PERMIT    2
`define NVM_BIT_WSTART    1
`define NVM_BIT_RSTART    0

// peripheral_flags_two and mask field position
`define NVM_BIT_DONE      4

// unlock keys written to the sequence port before a write start
`define NVM_KEY_FIRST     8'h55
`define NVM_KEY_SECOND    8'hAA

// reset and erased values
`define NVM_RST_BYTE      8'h00
`define NVM_RST_WORD      32'h0000_0000
`define NVM_ERASED_BYTE   8'hFF

// timing
`define NVM_CLK_MHZ       25
`define NVM_ERASE_TIME_US 2000
`define NVM_PROG_TIME_US  2000
`define NVM_CNT_W         24

`endif

/* File: verilog/nvm_pkg.sv */
// types for the nonvolatile data memory access controller
// assumes nvm_cfg.svh is included by every user of these types
package nvm_pkg;

   // controller sequencing states, one-hot
   typedef enum logic [3:0] {
      NVM_ST_IDLE  = 4'b0001,
      NVM_ST_READ  = 4'b0010,
      NVM_ST_ERASE = 4'b0100,
      NVM_ST_PROG  = 4'b1000
   } nvm_state_t;

   // whole state of the controller
   typedef struct packed {
      nvm_state_t  state;
      logic [23:0] cnt;
      logic        pss;
      logic        config_space_select;
      logic        fault;
      logic        permit;
      logic        wstart;
      logic        rstart;
      logic [7:0]  data;
      logic [7:0]  addr;
      logic [1:0]  unlock;
      logic [7:0]  wdata_l;
      logic [7:0]  waddr_l;
      logic        op_data;
      logic        done;
      logic        mask_done;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
      logic        rst_seen;
   } nvm_regs_t;

endpackage

/* File: verilog/nvm_array.sv */
// byte-wide nonvolatile data array with one read and one write port
// assumes the controller never erases and programs in the same cycle
`timescale 1ns/100ps
`include "nvm_cfg.svh"
module nvm_array #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk,
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic      [7:0]        rd_data,
   input  wire logic              erase_en,
   input  wire logic              prog_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [7:0]        wr_data
);

   logic [7:0] mem [0:(1<<ADDR_W)-1];

   // no reset: contents survive like the real array
   always_ff @(posedge clk) begin
      if (erase_en) begin
         mem[wr_addr] <= `NVM_ERASED_BYTE;
      end else if (prog_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule // nvm_array

/* File: verilog/nvm_ctrl.sv */
// access controller for the on-chip nonvolatile data memory
// assumes an APB master on clk; reset rst is synchronous, active high
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "nvm_cfg.svh"
module nvm_ctrl #(
   parameter int ADDR_W       = 8,
   parameter int ERASE_CYCLES = `NVM_ERASE_TIME_US * `NVM_CLK_MHZ,
   parameter int PROG_CYCLES  = `NVM_PROG_TIME_US * `NVM_CLK_MHZ
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic             space_pss,
   output logic             space_config_space_select,
   output logic             busy
);

   // elaboration checks
   if (ADDR_W < 1 || ADDR_W > 8) begin : g_chk_addr
      $error("ADDR_W must lie in 1..8");
   end
   if (ERASE_CYCLES < 1 || ERASE_CYCLES > (1 << `NVM_CNT_W)) begin : g_chk_er
      $error("ERASE_CYCLES out of counter range");
   end
   if (PROG_CYCLES < 1 || PROG_CYCLES > (1 << `NVM_CNT_W)) begin : g_chk_pr
      $error("PROG_CYCLES out of counter range");
   end

   localparam logic [23:0] ERASE_LAST = 24'(ERASE_CYCLES - 1);
   localparam logic [23:0] PROG_LAST  = 24'(PROG_CYCLES - 1);

   nvm_pkg::nvm_regs_t r;
   nvm_pkg::nvm_regs_t n;

   logic       acc_first;
   logic       commit_wr;
   logic [7:0] ctl_rd;
   logic [7:0] flag_rd;
   logic [7:0] mask_rd;
   logic [7:0] arr_rd;
   logic       arr_erase;
   logic       arr_prog;
   logic       busy_wr;

   // memory array
   nvm_array #(
      .ADDR_W (ADDR_W)
   ) u_array (
      .clk      (clk),
      .rd_addr  (r.addr[ADDR_W-1:0]),
      .rd_data  (arr_rd),
      .erase_en (arr_erase),
      .prog_en  (arr_prog),
      .wr_addr  (r.waddr_l[ADDR_W-1:0]),
      .wr_data  (r.wdata_l)
   );

   // array strobes: erase on first erase cycle, program on last
   assign arr_erase = (r.state == nvm_pkg::NVM_ST_ERASE) &&
                      (r.cnt == 24'h00_0000) && r.op_data;
   assign arr_prog  = (r.state == nvm_pkg::NVM_ST_PROG) &&
                      (r.cnt == PROG_LAST) && r.op_data;

   // readback images of the control-type registers
   assign ctl_rd  = {r.pss, r.config_space_select, 2'b00, r.fault, r.permit,
                     r.wstart, r.rstart};
   assign flag_rd = {3'b000, r.done, 4'h0};
   assign mask_rd = {3'b000, r.mask_done, 4'h0};

   // APB phases: answer prepared in first access cycle, taken in second
   assign acc_first = psel && penable && !r.pready;
   assign commit_wr = psel && penable && r.pready && pwrite;
   assign busy_wr   = (r.state == nvm_pkg::NVM_ST_ERASE) ||
                      (r.state == nvm_pkg::NVM_ST_PROG);

   // next-state logic
   always_comb begin
      n = r;
      n.pready   = 1'b0;
      n.pslverr  = 1'b0;
      n.rst_seen = 1'b0;

      // read data and error answer for the coming pready cycle
      if (acc_first) begin
         n.pready = 1'b1;
         n.prdata = `NVM_RST_WORD;
         case (paddr)
            `NVM_OFS_CONTROL: begin
               n.prdata = {24'h00_0000, ctl_rd};
            end
            `NVM_OFS_SEQUENCE: begin
               n.prdata = `NVM_RST_WORD;
            end
            `NVM_OFS_DATA: begin
               n.prdata = {24'h00_0000, r.data};
            end
            `NVM_OFS_LOCATION: begin
               n.prdata = {24'h00_0000, r.addr};
            end
            `NVM_OFS_FLAGS: begin
               n.prdata = {24'h00_0000, flag_rd};
            end
            `NVM_OFS_MASK: begin
               n.prdata = {24'h00_0000, mask_rd};
            end
            default: begin
               n.pslverr = 1'b1;
            end
         endcase
      end

      // register writes, taken at the pready edge
      if (commit_wr) begin
         case (paddr)
            `NVM_OFS_CONTROL: begin
               n.pss    = pwdata[`NVM_BIT_PSS];
               n.config_space_select   = pwdata[`NVM_BIT_CONFIG_SPACE_SELECT];
               n.permit = pwdata[`NVM_BIT_PERMIT];
               // fault flag cleared by software writing zero, or by a reset that cuts no write short
               if (!pwdata[`NVM_BIT_FAULT]) begin
                  n.fault = 1'b0;
               end
               // write start: set-only, needs permit and unlock
               if (pwdata[`NVM_BIT_WSTART] && !r.wstart &&
                   r.state == nvm_pkg::NVM_ST_IDLE) begin
                  if (r.permit && r.unlock == 2'd2) begin
                     n.wstart  = 1'b1;
                     n.waddr_l = r.addr;
                     n.wdata_l = r.data;
                     n.op_data = !pwdata[`NVM_BIT_PSS] &&
                                 !pwdata[`NVM_BIT_CONFIG_SPACE_SELECT];
                     n.state   = nvm_pkg::NVM_ST_ERASE;
                     n.cnt     = 24'h00_0000;
                  end else begin
                     n.fault   = 1'b1;
                  end
                  n.unlock = 2'd0;
               end else if (pwdata[`NVM_BIT_RSTART] &&
                            !pwdata[`NVM_BIT_PSS] &&
                            r.state == nvm_pkg::NVM_ST_IDLE) begin
                  // refused while program space is selected
                  n.rstart  = 1'b1;
                  n.op_data = !pwdata[`NVM_BIT_CONFIG_SPACE_SELECT];
                  n.state   = nvm_pkg::NVM_ST_READ;
               end
            end
            `NVM_OFS_SEQUENCE: begin
               // unlock keys, no storage behind the port
               if (pwdata[7:0] == `NVM_KEY_FIRST) begin
                  n.unlock = 2'd1;
               end else if (pwdata[7:0] == `NVM_KEY_SECOND &&
                            r.unlock == 2'd1) begin
                  n.unlock = 2'd2;
               end else begin
                  n.unlock = 2'd0;
               end
            end
            `NVM_OFS_DATA: begin
               n.data = pwdata[7:0];
            end
            `NVM_OFS_LOCATION: begin
               n.addr = pwdata[7:0];
            end
            `NVM_OFS_FLAGS: begin
               // write one to clear
               if (pwdata[`NVM_BIT_DONE]) begin
                  n.done = 1'b0;
               end
            end
            `NVM_OFS_MASK: begin
               n.mask_done = pwdata[`NVM_BIT_DONE];
            end
            default: begin
            end
         endcase
      end

      // operation sequencer; completion comes after the clear so set wins
      unique case (r.state)
         nvm_pkg::NVM_ST_IDLE: begin
         end
         nvm_pkg::NVM_ST_READ: begin
            // array output already reflects r.addr
            n.data   = r.op_data ? arr_rd : `NVM_RST_BYTE;
            n.rstart = 1'b0;
            n.state  = nvm_pkg::NVM_ST_IDLE;
         end
         nvm_pkg::NVM_ST_ERASE: begin
            if (r.cnt == ERASE_LAST) begin
               n.cnt   = 24'h00_0000;
               n.state = nvm_pkg::NVM_ST_PROG;
            end else begin
               n.cnt = r.cnt + 24'h00_0001;
            end
         end
         nvm_pkg::NVM_ST_PROG: begin
            if (r.cnt == PROG_LAST) begin
               n.cnt    = 24'h00_0000;
               n.wstart = 1'b0;
               n.done   = 1'b1;
               n.state  = nvm_pkg::NVM_ST_IDLE;
            end else begin
               n.cnt = r.cnt + 24'h00_0001;
            end
         end
      endcase

      // interrupt level from the next flag and mask values
      n.irq = n.done && n.mask_done;

      // synchronous reset; a cut-short write leaves the fault flag set,
      // and later edges of the same reset keep it set
      if (rst) begin
         n          = '0;
         n.state    = nvm_pkg::NVM_ST_IDLE;
         n.rst_seen = 1'b1;
         if (busy_wr) begin
            n.fault = 1'b1;
         end else if (r.rst_seen && r.fault) begin
            n.fault = 1'b1;
         end
         n.permit   = 1'b0;
      end
   end

   // single state register
   always_ff @(posedge clk) begin
      r <= n;
   end

   // outputs straight from the state register
   assign prdata     = r.prdata;
   assign pready     = r.pready;
   assign pslverr    = r.pslverr;
   assign irq        = r.irq;
   assign space_pss  = r.pss;
   assign space_config_space_select = r.config_space_select;
   assign busy       = r.wstart;

endmodule // nvm_ctrl

/* File: sim/nvm_ctrl_properties.sv */
// assertions on the ports of nvm_ctrl
// assumes a bind from the bench with the count parameters
`timescale 1ns/100ps
`include "nvm_cfg.svh"
module nvm_ctrl_checker #(
   parameter int ERASE_CYCLES = 4,
   parameter int PROG_CYCLES  = 5
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq,
   input wire logic        space_pss,
   input wire logic        space_config_space_select,
   input wire logic        busy
);
   localparam int TOTAL = ERASE_CYCLES + PROG_CYCLES;
   logic [15:0] busy_cnt_r;
   logic        ctl_wr;
   logic        wd_pss;
   logic        wd_config_space_select;
   logic        wd_ws;
   // committed control write and its fields
   assign ctl_wr  = psel && penable && pready && pwrite
                    && paddr == `NVM_OFS_CONTROL;
   assign wd_pss  = pwdata[`NVM_BIT_PSS];
   assign wd_config_space_select = pwdata[`NVM_BIT_CONFIG_SPACE_SELECT];
   assign wd_ws   = pwdata[`NVM_BIT_WSTART];
   // cycles spent busy
   always_ff @(posedge clk) begin
      if (rst || !busy)
         busy_cnt_r <= 16'h0000;
      else
         busy_cnt_r <= busy_cnt_r + 16'h0001;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence setup_s; psel && !penable; endsequence
   sequence answer_s; !pready ##1 pready; endsequence
   chk_pready_wait: assert property (setup_s |=> answer_s)
      else $error("pready not in second access cycle");
   chk_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_unmapped_err: assert property (pready |-> pslverr ==
      !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14}))
      else $error("pslverr wrong for address");
   chk_seq_zero: assert property (pready && !pwrite &&
      paddr == `NVM_OFS_SEQUENCE |-> prdata == 32'h0000_0000)
      else $error("sequence port read not zero");
   chk_busy_bound: assert property (busy |-> busy_cnt_r < TOTAL)
      else $error("write runs too long");
   // a reset that cuts a write short is not a completion
   chk_busy_full: assert property ($fell(busy) && !rst |->
      busy_cnt_r == TOTAL)
      else $error("write length wrong");
   chk_busy_cause: assert property ($rose(busy) |-> $past(ctl_wr) && $past(wd_ws))
      else $error("busy without write start");
   chk_pss_follow: assert property (!$stable(space_pss) |->
      $past(ctl_wr) && space_pss == $past(wd_pss))
      else $error("program select changed wrongly");
   chk_config_space_select_follow: assert property (!$stable(space_config_space_select) |->
      $past(ctl_wr) && space_config_space_select == $past(wd_config_space_select))
      else $error("config select changed wrongly");
   chk_read_no_write: assert property (ctl_wr && !busy && !wd_ws |=> !busy)
      else $error("read started a write");
endmodule // nvm_ctrl_checker

/* File: sim/nvm_mem_model.sv */
// expected contents of the nonvolatile data array
// assumes the bench reports each accepted data-space write
`timescale 1ns/100ps
module nvm_mem_model (
   input  wire logic       clk,
   input  wire logic       wr_en,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] rd_data
);
   logic [7:0] mem_r [256];
   // byte replaced whole, erase then program
   always_ff @(posedge clk) begin
      if (wr_en)
         mem_r[addr] <= wr_data;
   end
   assign rd_data = mem_r[addr];
endmodule // nvm_mem_model

/* File: sim/testbench.sv */
// self-checking bench for nvm_ctrl over APB
// assumes nvm_cfg.svh on the include path
`timescale 1ns/100ps
`include "nvm_cfg.svh"
module testbench;
   localparam logic [7:0] CTL = `NVM_OFS_CONTROL;
   localparam logic [7:0] SEQ = `NVM_OFS_SEQUENCE;
   localparam logic [7:0] DAT = `NVM_OFS_DATA;
   localparam logic [7:0] FLG = `NVM_OFS_FLAGS;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic        pready, pslverr, irq, space_pss, space_config_space_select, busy, e;
   logic        mw_en = 1'b0;
   logic [7:0]  md = 8'h00;
   logic [7:0]  mq;
   logic [7:0]  spc [2] = '{8'h86, 8'h46};
   int          miscompares = 0;
   int          n_compared = 0;
   int          cycles = 0;
   always #20 clk = ~clk;
   nvm_ctrl #(.ERASE_CYCLES(4), .PROG_CYCLES(5)) nvm_ctrl_i (.clk(clk),
      .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .space_pss(space_pss),
      .space_config_space_select(space_config_space_select), .busy(busy));
   nvm_mem_model nvm_mem_model_i (.clk(clk), .wr_en(mw_en), .addr(8'h21),
      .wr_data(md), .rd_data(mq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one APB transfer, waits for pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no local limit: only the hang limit ends this wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
   endtask
   task automatic idle(input int k);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (k) @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x);
      chk(32'(e), 32'(a > `NVM_OFS_MASK));
   endtask
   task automatic unlock;
      apb(1'b1, SEQ, 32'h55);
      apb(1'b1, SEQ, 32'hAA);
   endtask
   // wait for the write to finish
   task automatic drain;
      int n;
      n = 0;
      idle(1);
      while (busy !== 1'b0 && n < 64) begin
         @(posedge clk);
         n++;
      end
      chk(32'(busy), 32'h0);
      // a write that never ends stops the run here
      if (n >= 64) begin
         conclude;
      end
   endtask
   task automatic conclude;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hang limit
   always @(posedge clk) begin
      cycles++;
      if (cycles > 3000) begin
         miscompares++;
         conclude;
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(CTL, 32'h0);
      rd(FLG, 32'h0);
      apb(1'b1, SEQ, 32'h55);
      rd(SEQ, 32'h0);
      rd(8'h18, 32'h0);
      apb(1'b1, CTL, 32'h02);
      rd(CTL, 32'h08);
      chk(32'(busy), 32'h0);
      apb(1'b1, CTL, 32'h00);
      $display("test reset and refusal done");
      apb(1'b1, `NVM_OFS_LOCATION, 32'h21);
      apb(1'b1, DAT, 32'h5A);
      apb(1'b1, CTL, 32'h04);
      unlock;
      apb(1'b1, CTL, 32'h06);
      rd(CTL, 32'h06);
      apb(1'b1, CTL, 32'h04);
      chk(32'(busy), 32'h1);
      md <= 8'h5A;
      mw_en <= 1'b1;
      drain;
      mw_en <= 1'b0;
      rd(FLG, 32'h10);
      chk(32'(irq), 32'h0);
      apb(1'b1, `NVM_OFS_MASK, 32'h10);
      idle(2);
      chk(32'(irq), 32'h1);
      apb(1'b1, FLG, 32'h10);
      idle(2);
      chk(32'(irq), 32'h0);
      apb(1'b1, DAT, 32'h0);
      apb(1'b1, CTL, 32'h05);
      rd(DAT, {24'h0, mq});
      rd(CTL, 32'h04);
      $display("test data write and read done");
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, DAT, 32'h33);
         unlock;
         apb(1'b1, CTL, {24'h0, spc[i]});
         idle(1);
         chk(32'({space_pss, space_config_space_select}), 32'(spc[i][7:6]));
         drain;
         apb(1'b1, CTL, {24'h0, spc[i][7:6], 6'h01});
         rd(DAT, (i == 0) ? 32'h33 : 32'h0);
         apb(1'b1, CTL, 32'h05);
         rd(DAT, {24'h0, mq});
      end
      $display("test other spaces done");
      unlock;
      apb(1'b1, CTL, 32'h06);
      idle(2);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(CTL, 32'h08);
      chk(32'(busy), 32'h0);
      $display("test reset in write done");
      conclude;
   end
endmodule // testbench
bind nvm_ctrl nvm_ctrl_checker #(.ERASE_CYCLES(ERASE_CYCLES),
   .PROG_CYCLES(PROG_CYCLES)) nvm_ctrl_checker_i (.clk(clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq(irq), .space_pss(space_pss), .space_config_space_select(space_config_space_select), .busy(busy));
